// ### shared/bit_unit_defs.svh
// Encodings, field positions and widths for the bit set / bit test skip unit.
// Assumes a 12-bit instruction word and a 32 x 8 file register space.
// Functional notes
// - Opcode nibble 0110 with bit index and file address tests bit, skips when zero.
// - Next instruction word is fetched while the bit test executes.
// - On a taken skip the prefetched word is dropped with no effect at all.
// - Taken skip runs a no-operation, so the test takes two cycles, else one.
`ifndef BIT_UNIT_DEFS_SVH
`define BIT_UNIT_DEFS_SVH

`define WORD_W          12
`define DATA_W          8
`define ADDR_W          5
`define BIT_IDX_W       3
`define OPC_HI          11
`define OPC_LO          8
`define BIT_HI          7
`define BIT_LO          5
`define ADDR_HI         4
`define ADDR_LO         0
`define OPC_SET_BIT     4'h5
`define OPC_TEST_CLEAR  4'h6
`define NOP_WORD        12'h000
`define PHASES_PER_CYC  4

`endif

// ### shared/bit_unit_pkg.sv
// Types shared by the bit set / bit test skip unit.
// Assumes the constants header is compiled alongside.
package bit_unit_pkg;

    typedef enum logic [1:0] {
        PH_ADDR,
        PH_DATA,
        PH_EXEC,
        PH_COMMIT
    } phase_type;

    typedef enum logic [1:0] {
        KIND_OTHER,
        KIND_SET_BIT,
        KIND_TEST_CLEAR
    } kind_type;

endpackage

// ### shared/file_port_if.sv
// Port between the execution unit and its file register memory.
// Assumes both ends run on ref_clk.
`timescale 1ns/10ps
`include "bit_unit_defs.svh"

interface file_port_if;
    logic [`ADDR_W-1:0] rd_addr;
    logic [`DATA_W-1:0] rd_data;
    logic               wr_en;
    logic [`ADDR_W-1:0] wr_addr;
    logic [`DATA_W-1:0] wr_data;

    modport unit (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
    modport mem  (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

// ### logic/file_reg_mem.sv
// File register storage with one write port and two registered read ports.
// Assumes a synchronous reset copy from the top; contents clear at reset.
`timescale 1ns/10ps
`include "bit_unit_defs.svh"

module file_reg_mem #(
    parameter int DEPTH = 32
) (
    input  wire logic               ref_clk,   // Core clock
    input  wire logic               rst_n,     // Synchronised reset, active low
    file_port_if.mem                port,      // Unit access
    input  wire logic [`ADDR_W-1:0] peek_addr, // Observation address
    output logic      [`DATA_W-1:0] peek_data  // Observation data, registered
);

    // Refuse a depth that the address field cannot reach exactly
    if (DEPTH != (1 << `ADDR_W)) begin : g_depth_check
        $error("file_reg_mem: DEPTH must match the address width");
    end

    logic [`DATA_W-1:0] mem_q [DEPTH];
    logic [`DATA_W-1:0] rd_q;
    logic [`DATA_W-1:0] peek_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (port.wr_en) begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q   <= 8'h00;
            peek_q <= 8'h00;
        end else begin
            rd_q   <= mem_q[port.rd_addr];
            peek_q <= mem_q[peek_addr];
        end
    end

    assign port.rd_data = rd_q;
    assign peek_data    = peek_q;

endmodule

// ### logic/bit_set_test_skip_unit.sv
// Execution of the bit set and bit test skip-if-zero instructions.
// Assumes instr_word comes from the fetch path on ref_clk and holds the word
// two addresses after the executing one; one instruction cycle is four
// ref_clk phases (address, data, execute, commit).
`timescale 1ns/10ps
`include "bit_unit_defs.svh"

module bit_set_test_skip_unit (
    input  wire logic               ref_clk,       // 10 MHz core clock
    input  wire logic               rst_n,         // Asynchronous reset, active low
    input  wire logic [`WORD_W-1:0] instr_word,    // Word presented by fetch
    input  wire logic               ext_wr_en,     // Datapath write strobe
    input  wire logic [`ADDR_W-1:0] ext_wr_addr,   // Datapath write address
    input  wire logic [`DATA_W-1:0] ext_wr_data,   // Datapath write data
    input  wire logic [`ADDR_W-1:0] peek_addr,     // Observation address
    output logic      [`DATA_W-1:0] peek_data_q,   // Observation data
    output logic                    fetch_take_q,  // Pulse: instr_word taken
    output logic      [`WORD_W-1:0] exec_word_q,   // Word in execution
    output logic                    exec_valid_q,  // Executing word is real
    output logic                    skip_nop_q,    // Executing the skip filler
    output logic                    cycle_start_q, // Pulse: first phase of a cycle
    output logic                    bit_zero_q     // Last tested bit was zero
);

    // Reset release through two flip-flops
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    file_port_if fport ();

    logic [`DATA_W-1:0] peek_data;

    file_reg_mem #(
        .DEPTH (32)
    ) u_mem (
        .ref_clk   (ref_clk),
        .rst_n     (rst_sync_q),
        .port      (fport),
        .peek_addr (peek_addr),
        .peek_data (peek_data)
    );

    bit_unit_pkg::phase_type phase_q;
    bit_unit_pkg::phase_type phase_d;
    logic [`WORD_W-1:0]      fetch_q;
    logic                    fetch_valid_q;
    logic [`DATA_W-1:0]      data_q;
    logic                    skip_q;
    logic                    set_wr_q;

    bit_unit_pkg::kind_type  kind;
    logic [`BIT_IDX_W-1:0]   bit_idx;
    logic [`ADDR_W-1:0]      f_addr;
    logic [`DATA_W-1:0]      bit_mask;
    logic                    cycle_end;
    logic                    bit_is_zero;

    assign bit_idx   = exec_word_q[`BIT_HI:`BIT_LO];
    assign f_addr    = exec_word_q[`ADDR_HI:`ADDR_LO];
    assign bit_mask  = 8'h01 << bit_idx;
    assign cycle_end = (phase_q == bit_unit_pkg::PH_COMMIT);
    assign bit_is_zero = ((data_q & bit_mask) == 8'h00);

    always_comb begin
        kind = bit_unit_pkg::KIND_OTHER;
        if (exec_valid_q) begin
            case (exec_word_q[`OPC_HI:`OPC_LO])
                `OPC_SET_BIT:    kind = bit_unit_pkg::KIND_SET_BIT;
                `OPC_TEST_CLEAR: kind = bit_unit_pkg::KIND_TEST_CLEAR;
                default:         kind = bit_unit_pkg::KIND_OTHER;
            endcase
        end
    end

    // Phase sequencer, one enable per instruction cycle
    always_comb begin
        case (phase_q)
            bit_unit_pkg::PH_ADDR:   phase_d = bit_unit_pkg::PH_DATA;
            bit_unit_pkg::PH_DATA:   phase_d = bit_unit_pkg::PH_EXEC;
            bit_unit_pkg::PH_EXEC:   phase_d = bit_unit_pkg::PH_COMMIT;
            bit_unit_pkg::PH_COMMIT: phase_d = bit_unit_pkg::PH_ADDR;
            default:                 phase_d = bit_unit_pkg::PH_ADDR;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            phase_q <= bit_unit_pkg::PH_ADDR;
        end else begin
            phase_q <= phase_d;
        end
    end

    // First clock of each instruction cycle
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            cycle_start_q <= 1'b0;
        end else begin
            cycle_start_q <= cycle_end;
        end
    end

    // Operand read: address in phase 0, registered data in phase 1
    assign fport.rd_addr = f_addr;

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            data_q <= 8'h00;
        end else if (phase_q == bit_unit_pkg::PH_DATA) begin
            data_q <= fport.rd_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            skip_q <= 1'b0;
        end else if (phase_q == bit_unit_pkg::PH_EXEC) begin
            skip_q <= (kind == bit_unit_pkg::KIND_TEST_CLEAR) && bit_is_zero;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            bit_zero_q <= 1'b0;
        end else if ((phase_q == bit_unit_pkg::PH_EXEC) && (kind == bit_unit_pkg::KIND_TEST_CLEAR)) begin
            bit_zero_q <= bit_is_zero;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            set_wr_q <= 1'b0;
        end else begin
            set_wr_q <= (phase_q == bit_unit_pkg::PH_EXEC) &&
                        (kind == bit_unit_pkg::KIND_SET_BIT);
        end
    end

    // Unit write lands in the commit phase; datapath writes otherwise
    // A datapath write in that same clock is lost, the unit wins
    always_comb begin
        fport.wr_en   = ext_wr_en;
        fport.wr_addr = ext_wr_addr;
        fport.wr_data = ext_wr_data;
        if (set_wr_q) begin
            fport.wr_en   = 1'b1;
            fport.wr_addr = f_addr;
            fport.wr_data = data_q | bit_mask;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            fetch_q       <= `NOP_WORD;
            fetch_valid_q <= 1'b0;
        end else if (cycle_end) begin
            fetch_q       <= instr_word;
            fetch_valid_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            fetch_take_q <= 1'b0;
        end else begin
            fetch_take_q <= cycle_end;
        end
    end

    // A taken skip swaps the prefetched word for the filler, so the dropped
    // word never reaches decode and cannot write or test anything
    // discard prefetched word
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            exec_word_q  <= `NOP_WORD;
            exec_valid_q <= 1'b0;
        end else if (cycle_end) begin
            if (skip_q) begin
                exec_word_q  <= `NOP_WORD;
                exec_valid_q <= 1'b0;
            end else begin
                exec_word_q  <= fetch_q;
                exec_valid_q <= fetch_valid_q;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            skip_nop_q <= 1'b0;
        end else if (cycle_end) begin
            skip_nop_q <= skip_q;
        end
    end

    // Observation data straight from a flop
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            peek_data_q <= 8'h00;
        end else begin
            peek_data_q <= peek_data;
        end
    end

endmodule

// ### dv/bit_set_test_skip_unit_monitor.sv
// Port-level checker for the bit set / bit test skip unit.
// Assumes a single ref_clk domain with rst_n as its reset.
`timescale 1ns/10ps
`include "bit_unit_defs.svh"

module bit_set_test_skip_unit_monitor (
    input wire logic               ref_clk,       // Core clock
    input wire logic               rst_n,         // Reset, active low
    input wire logic               fetch_take_q,  // Fetch pulse
    input wire logic [`WORD_W-1:0] exec_word_q,   // Executing word
    input wire logic               exec_valid_q,  // Real word flag
    input wire logic               skip_nop_q,    // Filler flag
    input wire logic               cycle_start_q, // Cycle pulse
    input wire logic               bit_zero_q     // Last test result
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_take_with_start;
        fetch_take_q == cycle_start_q;
    endproperty
    a_take_with_start: assert property (p_take_with_start)
        else $error("fetch pulse apart from cycle pulse");

    property p_cycle_len;
        cycle_start_q |=> !cycle_start_q [*3] ##1 cycle_start_q;
    endproperty
    a_cycle_len: assert property (p_cycle_len)
        else $error("instruction cycle is not four clocks");

    property p_filler;
        skip_nop_q |-> exec_word_q == `NOP_WORD && !exec_valid_q;
    endproperty
    a_filler: assert property (p_filler)
        else $error("filler cycle carries a real word");

    property p_filler_len;
        $rose(skip_nop_q) |-> skip_nop_q [*4] ##1 !skip_nop_q;
    endproperty
    a_filler_len: assert property (p_filler_len)
        else $error("filler does not last one cycle");

    property p_skip_cause;
        cycle_start_q && $past(exec_valid_q)
            && $past(exec_word_q[`OPC_HI:`OPC_LO]) == `OPC_TEST_CLEAR
            |-> skip_nop_q == bit_zero_q;
    endproperty
    a_skip_cause: assert property (p_skip_cause)
        else $error("skip does not follow tested bit");

    property p_set_no_skip;
        cycle_start_q && $past(exec_valid_q)
            && $past(exec_word_q[`OPC_HI:`OPC_LO]) == `OPC_SET_BIT
            |-> !skip_nop_q && exec_valid_q;
    endproperty
    a_set_no_skip: assert property (p_set_no_skip)
        else $error("bit set disturbed the next cycle");

    property p_flag_source;
        $changed(bit_zero_q) |-> exec_valid_q
            && exec_word_q[`OPC_HI:`OPC_LO] == `OPC_TEST_CLEAR;
    endproperty
    a_flag_source: assert property (p_flag_source)
        else $error("zero flag moved outside a bit test");

    property p_filler_quiet;
        skip_nop_q |-> $stable(bit_zero_q);
    endproperty
    a_filler_quiet: assert property (p_filler_quiet)
        else $error("discarded word changed the test flag");
endmodule

bind bit_set_test_skip_unit bit_set_test_skip_unit_monitor bit_set_test_skip_unit_monitor_i (
    .ref_clk, .rst_n, .fetch_take_q, .exec_word_q, .exec_valid_q, .skip_nop_q,
    .cycle_start_q, .bit_zero_q
);

// ### dv/bit_set_test_skip_unit_bench.sv
// Self-checking bench for the bit set / bit test skip unit.
// Assumes the unit's header and package are compiled first.
`timescale 1ns/10ps
`include "bit_unit_defs.svh"

module bit_set_test_skip_unit_bench;
    typedef struct packed {
        logic [`WORD_W-1:0] word;
        logic               dropped;
        logic               zero;
    } row_type;

    localparam int N_ROWS = 12;
    // Word stream, whether a preceding skip drops it, zero flag as its cycle starts
    localparam row_type ROWS [N_ROWS] = '{
        '{12'h5e3, 1'b0, 1'b0}, '{12'h6e3, 1'b0, 1'b0}, '{12'h503, 1'b0, 1'b0},
        '{12'h623, 1'b0, 1'b0}, '{12'h55f, 1'b1, 1'b1}, '{12'h65f, 1'b0, 1'b1},
        '{12'h603, 1'b1, 1'b1}, '{12'h603, 1'b0, 1'b1}, '{12'h5a0, 1'b0, 1'b0},
        '{12'h6a0, 1'b0, 1'b0}, '{12'ha12, 1'b0, 1'b0}, '{12'h000, 1'b0, 1'b0}};

    logic               ref_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic [`WORD_W-1:0] instr_word = ROWS[0].word;
    logic [`ADDR_W-1:0] peek_addr = 5'h00;
    logic [`DATA_W-1:0] peek_data_q;
    logic [`WORD_W-1:0] exec_word_q;
    logic               fetch_take_q, exec_valid_q, skip_nop_q, cycle_start_q, bit_zero_q;
    int                 err_total = 0;
    int                 n_checks = 0;

    bit_set_test_skip_unit bit_set_test_skip_unit_i (
        .ref_clk, .rst_n, .instr_word,
        .ext_wr_en   (1'b0),
        .ext_wr_addr (5'h00),
        .ext_wr_data (8'h00),
        .peek_addr, .peek_data_q, .fetch_take_q, .exec_word_q,
        .exec_valid_q, .skip_nop_q, .cycle_start_q, .bit_zero_q
    );

    always #50 ref_clk = ~ref_clk;

    task automatic check_word(input logic [`WORD_W-1:0] got, input logic [`WORD_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic peek_check(input logic [`ADDR_W-1:0] addr, input logic [`DATA_W-1:0] exp);
        peek_addr = addr;
        repeat (3) @(negedge ref_clk);
        check_word({4'h0, peek_data_q}, {4'h0, exp});
    endtask

    task automatic print_verdict;
        $display("Checks %0d, errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        for (int i = 0; i <= N_ROWS; i++) begin
            while (fetch_take_q !== 1'b1) @(negedge ref_clk);
            if (i > 0) begin
                check_word(exec_word_q, ROWS[i-1].dropped ? `NOP_WORD : ROWS[i-1].word);
                check_bit(skip_nop_q, ROWS[i-1].dropped);
                check_bit(exec_valid_q, !ROWS[i-1].dropped);
                check_bit(bit_zero_q, ROWS[i-1].zero);
            end
            instr_word = (i + 1 < N_ROWS) ? ROWS[i+1].word : `NOP_WORD;
            @(negedge ref_clk);
        end
        peek_check(5'd3, 8'h81);
        peek_check(5'd31, 8'h00);
        peek_check(5'd0, 8'h20);
        rst_n = 1'b0;
        @(negedge ref_clk);
        check_word(exec_word_q, `NOP_WORD);
        check_bit(exec_valid_q | skip_nop_q | fetch_take_q | bit_zero_q, 1'b0);
        rst_n = 1'b1;
        peek_check(5'd3, 8'h00);
        while (fetch_take_q !== 1'b1) @(negedge ref_clk);
        check_bit(exec_valid_q, 1'b0);
        print_verdict();
    end

    initial begin
        #50us;
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
